// *** analog_diag_defines.svh ***
`ifndef ANALOG_DIAG_DEFINES_SVH
`define ANALOG_DIAG_DEFINES_SVH

// Record set numbers
`define REC_SET_SHORT     8'h00
`define REC_SET_FULL      8'h01

// Record lengths in bytes
`define REC_LEN_SHORT     5'h04
`define REC_LEN_FULL      5'h10

// Byte offsets inside the record
`define OFS_GENERAL       5'h00
`define OFS_MODULE_INFO   5'h01
`define OFS_RESERVED      5'h02
`define OFS_COMM          5'h03
`define OFS_CHANNEL_TYPE  5'h04
`define OFS_DIAG_BITS     5'h05
`define OFS_CHANNEL_COUNT 5'h06
`define OFS_SUMMARY       5'h07
`define OFS_DETAIL0       5'h08

// Field values
`define MOD_CLASS_ANALOG  4'h5
`define MODULE_INFO_VAL   8'h15
`define DIAG_BITS_VAL     8'h08
`define CHANNEL_COUNT_VAL 8'h08
`define CHANNEL_TYPE_VAL  8'h71

// Reset values
`define GENERAL_RST       8'h00
`define COMM_RST          8'h00
`define SUMMARY_RST       8'h00
`define DETAIL_RST        8'h00

`endif

// *** analog_diag_pkg.sv ***
`default_nettype none

package analog_diag_pkg;

  typedef enum logic [6:0] {
    CH_DIGITAL_IN  = 7'h70,
    CH_ANALOG_IN   = 7'h71,
    CH_DIGITAL_OUT = 7'h72,
    CH_ANALOG_OUT  = 7'h73,
    CH_ANALOG_IO   = 7'h74,
    CH_COUNTER     = 7'h76
  } chan_type_e;

  typedef struct packed {
    logic       param_err;
    logic [1:0] rsvd;
    logic       aux_missing;
    logic       chan_err;
    logic       ext_err;
    logic       int_err;
    logic       failed;
  } general_diag_s;

  typedef struct packed {
    logic [2:0] rsvd;
    logic       chan_info;
    logic [3:0] mod_class;
  } module_info_s;

  typedef struct packed {
    logic [2:0] rsvd_hi;
    logic       comm_err;
    logic [3:0] rsvd_lo;
  } comm_diag_s;

  typedef struct packed {
    logic       over;
    logic       under;
    logic [4:0] rsvd;
    logic       param_err;
  } chan_detail_s;

endpackage : analog_diag_pkg

`default_nettype wire

// *** analog_input_diagnostic_record.sv ***
// What this block does
// RULE_01: Bit 0 of the general byte shows module failure.
// RULE_02: Bits 1 and 2 show internal and external error independently.
// RULE_03: Bit 3 of the general byte shows a channel error.
// RULE_04: Bit 4 shows a missing external auxiliary supply.
// RULE_05: Bit 7 of the general byte shows a parameterization error.
// RULE_06: Module information bits 3..0 hold class 0101b, analog.
// RULE_07: Module information bit 4 flags channel data present; 7..5 reserved.
// RULE_08: Bit 4 of the comm byte shows internal communication error.
// RULE_09: Channel type byte holds 71h, analog input; bit 7 reserved.
// RULE_10: Diagnostic bits per channel reads as constant 08h.
// RULE_11: Channel count reads as constant 08h.
// RULE_12: Summary bit n is set while channel n has an error.
// RULE_13: Detail bit 0 shows a channel parameter error; 5..1 reserved.
// RULE_14: Detail bit 6 shows a measured value below range.
// RULE_15: Detail bit 7 shows a measured value above range.
// RULE_16: No interrupt; errors light the channel lamp and enter the record.
// RULE_17: Set 01h reads the full record, set 00h the first four bytes.
// RULE_18: Every reserved bit reads as zero.
// RULE_19: General channel error is the OR of the summary bits.
`timescale 1ns/1ps
`default_nettype none
`include "analog_diag_defines.svh"

module analog_input_diagnostic_record
  import analog_diag_pkg::*;
#(
  parameter int                          VALUE_W     = 16,
  parameter logic signed [VALUE_W-1:0]   OVER_LIMIT  = 16'sh7EFF,
  parameter logic signed [VALUE_W-1:0]   UNDER_LIMIT = 16'sh8100
) (
  input  wire logic                 SYS_CLK_I,
  input  wire logic                 RST_B_I,
  input  wire logic                 MOD_FAIL_I,
  input  wire logic                 INT_ERR_I,
  input  wire logic                 EXT_ERR_I,
  input  wire logic                 AUX_MISSING_I,
  input  wire logic                 PARAM_ERR_I,
  input  wire logic                 COMM_ERR_I,
  input  wire logic [7:0]           CH_PARAM_ERR_I,
  input  wire logic [8*VALUE_W-1:0] CH_VALUE_I,
  input  wire logic                 RD_REQ_I,
  input  wire logic [7:0]           RECORD_SET_NUMBER_I,
  input  wire logic [4:0]           RD_INDEX_I,
  output var  logic                 RD_VALID_O,
  output var  logic [7:0]           RD_DATA_O,
  output var  logic                 RD_ERROR_O,
  output var  logic [7:0]           CH_LED_O
);

  localparam int NUM_CH = 8;

  // Stored record
  general_diag_s general_diagnostic;
  comm_diag_s    internal_comm_diagnostic;
  logic [7:0]    channel_error_summary;
  chan_detail_s  channel_error_detail [NUM_CH];

  // Live inputs
  logic          aux_sync;
  logic [7:0]    ch_under;
  logic [7:0]    ch_over;
  chan_detail_s  next_detail [NUM_CH];
  logic [7:0]    next_summary;
  general_diag_s next_general;
  comm_diag_s    next_comm;

  // Supply monitor is a board pin, not logic on this clock
  pin_sync #(
    .W (1)
  ) u_aux_sync (
    .clk_i   (SYS_CLK_I),
    .rst_b_i (RST_B_I),
    .d_i     (AUX_MISSING_I),
    .q_o     (aux_sync)
  );

  genvar g;
  generate
    for (g = 0; g < NUM_CH; g++) begin : g_chan
      range_monitor #(
        .VALUE_W     (VALUE_W),
        .OVER_LIMIT  (OVER_LIMIT),
        .UNDER_LIMIT (UNDER_LIMIT)
      ) u_range (
        .clk_i   (SYS_CLK_I),
        .rst_b_i (RST_B_I),
        .value_i (CH_VALUE_I[g*VALUE_W +: VALUE_W]),
        .under_o (ch_under[g]),
        .over_o  (ch_over[g])
      );

      assign next_detail[g] = '{
        over      : ch_over[g],         // RULE_15
        under     : ch_under[g],        // RULE_14
        rsvd      : 5'h00,              // RULE_18
        param_err : CH_PARAM_ERR_I[g]   // RULE_13
      };
      assign next_summary[g] = |next_detail[g]; // RULE_12

      always_ff @(posedge SYS_CLK_I or negedge RST_B_I) begin
        if (!RST_B_I) begin
          channel_error_detail[g] <= `DETAIL_RST;
        end else begin
          channel_error_detail[g] <= next_detail[g];
        end
      end

      a_summary_bit : assert property ( // RULE_12
        @(posedge SYS_CLK_I) disable iff (!RST_B_I)
        channel_error_summary[g] == (channel_error_detail[g] != 8'h00)
      ) else $error("summary bit disagrees with channel detail");

      a_param_detail : assert property ( // RULE_13
        @(posedge SYS_CLK_I) disable iff (!RST_B_I)
        CH_PARAM_ERR_I[g] |=> channel_error_detail[g].param_err
      ) else $error("channel parameter error not recorded");

      // Two edges: range flop first, then the record flop
      a_under_range : assert property ( // RULE_14
        @(posedge SYS_CLK_I) disable iff (!RST_B_I)
        ($signed(CH_VALUE_I[g*VALUE_W +: VALUE_W]) < UNDER_LIMIT) |-> ##2
          (channel_error_detail[g].under && CH_LED_O[g])
      ) else $error("underflow not recorded");

      a_over_range : assert property ( // RULE_15
        @(posedge SYS_CLK_I) disable iff (!RST_B_I)
        ($signed(CH_VALUE_I[g*VALUE_W +: VALUE_W]) > OVER_LIMIT) |-> ##2
          (channel_error_detail[g].over && channel_error_summary[g])
      ) else $error("overflow not recorded");
    end
  endgenerate

  assign next_general = '{
    param_err   : PARAM_ERR_I,    // RULE_05
    rsvd        : 2'b00,          // RULE_18
    aux_missing : aux_sync,       // RULE_04
    chan_err    : |next_summary,  // RULE_03 RULE_19
    ext_err     : EXT_ERR_I,      // RULE_02
    int_err     : INT_ERR_I,      // RULE_02
    failed      : MOD_FAIL_I      // RULE_01
  };

  assign next_comm = '{
    rsvd_hi  : 3'b000,
    comm_err : COMM_ERR_I,        // RULE_08
    rsvd_lo  : 4'h0
  };

  // Status is live; there is no latching, so a cleared cause clears its bit
  always_ff @(posedge SYS_CLK_I or negedge RST_B_I) begin
    if (!RST_B_I) begin
      general_diagnostic       <= `GENERAL_RST;
      internal_comm_diagnostic <= `COMM_RST;
      channel_error_summary    <= `SUMMARY_RST;
      CH_LED_O                 <= 8'h00;
    end else begin
      general_diagnostic       <= next_general;
      internal_comm_diagnostic <= next_comm;
      channel_error_summary    <= next_summary;
      CH_LED_O                 <= next_summary; // RULE_16
    end
  end

  // Record image, byte by byte
  module_info_s module_information;
  logic [7:0]   record_byte [16];

  assign module_information = '{
    rsvd      : 3'b000,             // RULE_18
    chan_info : 1'b1,               // RULE_07
    mod_class : `MOD_CLASS_ANALOG   // RULE_06
  };

  assign record_byte[0]  = general_diagnostic;
  assign record_byte[1]  = module_information;
  assign record_byte[2]  = 8'h00;                       // RULE_18
  assign record_byte[3]  = internal_comm_diagnostic;
  assign record_byte[4]  = {1'b0, CH_ANALOG_IN};         // RULE_09
  assign record_byte[5]  = `DIAG_BITS_VAL;               // RULE_10
  assign record_byte[6]  = `CHANNEL_COUNT_VAL;           // RULE_11
  assign record_byte[7]  = channel_error_summary;

  generate
    for (g = 0; g < NUM_CH; g++) begin : g_rec
      assign record_byte[8+g] = channel_error_detail[g];
    end
  endgenerate

  // Set 00h is a short view of the same bytes
  wire logic set_full  = RECORD_SET_NUMBER_I == `REC_SET_FULL;
  wire logic set_short = RECORD_SET_NUMBER_I == `REC_SET_SHORT;
  wire logic in_full   = RD_INDEX_I < `REC_LEN_FULL;
  wire logic in_short  = RD_INDEX_I < `REC_LEN_SHORT;
  wire logic req_ok    = RD_REQ_I &&
                         ((set_full && in_full) ||
                          (set_short && in_short)); // RULE_17
  wire logic [7:0] sel_byte = record_byte[RD_INDEX_I[3:0]];

  always_ff @(posedge SYS_CLK_I or negedge RST_B_I) begin
    if (!RST_B_I) begin
      RD_VALID_O <= 1'b0;
      RD_DATA_O  <= 8'h00;
      RD_ERROR_O <= 1'b0;
    end else begin
      RD_VALID_O <= RD_REQ_I;
      RD_DATA_O  <= req_ok ? sel_byte : 8'h00; // RULE_17
      RD_ERROR_O <= RD_REQ_I && !req_ok;
    end
  end

  default clocking cb @(posedge SYS_CLK_I); endclocking
  default disable iff (!RST_B_I);

  a_fail_flag : assert property ( // RULE_01
    MOD_FAIL_I |=> general_diagnostic.failed
  ) else $error("module failure not reported");

  a_int_ext_split : assert property ( // RULE_02
    (INT_ERR_I && !EXT_ERR_I) |=>
      (general_diagnostic.int_err && !general_diagnostic.ext_err)
  ) else $error("internal and external error not independent");

  a_chan_or : assert property ( // RULE_19
    general_diagnostic.chan_err == (channel_error_summary != 8'h00)
  ) else $error("channel error flag is not the summary OR");

  a_aux_delay : assert property ( // RULE_04
    AUX_MISSING_I [*3] |=> general_diagnostic.aux_missing
  ) else $error("missing supply not reported");

  a_param_flag : assert property ( // RULE_05
    PARAM_ERR_I |=> general_diagnostic.param_err
  ) else $error("parameterization error not reported");

  a_comm_flag : assert property ( // RULE_08
    COMM_ERR_I |=> (internal_comm_diagnostic == 8'h10)
  ) else $error("comm error byte wrong");

  a_modinfo_read : assert property ( // RULE_06
    (RD_REQ_I && set_full && RD_INDEX_I == `OFS_MODULE_INFO) |=>
      (RD_VALID_O && RD_DATA_O == `MODULE_INFO_VAL)
  ) else $error("module information byte wrong");

  a_chtype_read : assert property ( // RULE_09
    (RD_REQ_I && set_full && RD_INDEX_I == `OFS_CHANNEL_TYPE) |=>
      (RD_DATA_O == `CHANNEL_TYPE_VAL)
  ) else $error("channel type byte wrong");

  a_count_read : assert property ( // RULE_11
    (RD_REQ_I && set_full && RD_INDEX_I == `OFS_CHANNEL_COUNT) |=>
      (RD_DATA_O == `CHANNEL_COUNT_VAL && !RD_ERROR_O)
  ) else $error("channel count byte wrong");

  a_ext_int_split : assert property ( // RULE_02
    (EXT_ERR_I && !INT_ERR_I) |=>
      (general_diagnostic.ext_err && !general_diagnostic.int_err)
  ) else $error("external and internal error not independent");

  // Live status: a cleared parameterization error must clear its bit one edge later
  a_param_clear : assert property ( // RULE_05
    !PARAM_ERR_I |=> !general_diagnostic.param_err
  ) else $error("parameterization error stuck");

  a_chan_flag : assert property ( // RULE_03
    (|next_summary) |=> general_diagnostic.chan_err
  ) else $error("channel error not reported");

  a_modinfo_bits : assert property ( // RULE_07
    (RD_REQ_I && set_short && RD_INDEX_I == `OFS_MODULE_INFO) |=>
      (RD_DATA_O[4] && RD_DATA_O[7:5] == 3'h0)
  ) else $error("module information flags wrong");

  a_diagbits_read : assert property ( // RULE_10
    (RD_REQ_I && set_full && RD_INDEX_I == `OFS_DIAG_BITS) |=>
      (RD_DATA_O == `DIAG_BITS_VAL)
  ) else $error("diagnostic bit count wrong");

  a_rsvd_byte : assert property ( // RULE_18
    (RD_REQ_I && RD_INDEX_I == `OFS_RESERVED) |=> (RD_DATA_O == 8'h00)
  ) else $error("reserved byte not zero");

  // Answer stands one cycle only, so a stale byte never looks fresh
  a_read_idle : assert property ( // RULE_17
    !RD_REQ_I |=> (!RD_VALID_O && !RD_ERROR_O && RD_DATA_O == 8'h00)
  ) else $error("read answer without a request");

  a_error_data : assert property ( // RULE_17
    RD_ERROR_O |-> (RD_VALID_O && RD_DATA_O == 8'h00)
  ) else $error("refused read carries data");

  a_led_match : assert property ( // RULE_16
    CH_LED_O == channel_error_summary
  ) else $error("channel lamp disagrees with summary");

  a_short_set : assert property ( // RULE_17
    (RD_REQ_I && set_short && !in_short) |=>
      (RD_VALID_O && RD_ERROR_O && RD_DATA_O == 8'h00)
  ) else $error("short record set read past its end");

  a_rsvd_zero : assert property ( // RULE_18
    general_diagnostic.rsvd == 2'b00 &&
    channel_error_detail[3].rsvd == 5'h00
  ) else $error("reserved bits not zero");

endmodule : analog_input_diagnostic_record

`default_nettype wire

// *** analog_input_diagnostic_record_tb.sv ***
`timescale 1ns/1ps
`default_nettype none
`include "analog_diag_defines.svh"

module analog_input_diagnostic_record_tb
  import analog_diag_pkg::*;
;
  logic         clk;
  logic         rst_b;
  logic [5:0]   flags;
  logic [7:0]   ch_perr;
  logic [127:0] ch_val;
  logic         req;
  logic [7:0]   set;
  logic [4:0]   idx;
  logic         valid;
  logic [7:0]   data;
  logic         rerr;
  logic [7:0]   led;
  int           err_total;
  int           compares;
  int           cycles;
  chan_detail_s det;
  logic [7:0]   gexp [6] = '{8'h01, 8'h02, 8'h04, 8'h10, 8'h80, 8'h10};

  analog_input_diagnostic_record DUT (
    .SYS_CLK_I(clk), .RST_B_I(rst_b), .MOD_FAIL_I(flags[0]),
    .INT_ERR_I(flags[1]), .EXT_ERR_I(flags[2]), .AUX_MISSING_I(flags[3]),
    .PARAM_ERR_I(flags[4]), .COMM_ERR_I(flags[5]), .CH_PARAM_ERR_I(ch_perr),
    .CH_VALUE_I(ch_val), .RD_REQ_I(req), .RECORD_SET_NUMBER_I(set),
    .RD_INDEX_I(idx), .RD_VALID_O(valid), .RD_DATA_O(data),
    .RD_ERROR_O(rerr), .CH_LED_O(led));

  diag_reader rdr (
    .clk_i(clk), .rd_req_o(req), .set_o(set), .index_o(idx),
    .valid_i(valid), .data_i(data), .error_i(rerr));

  initial clk = 1'b0;
  always #20 clk = ~clk;

  task automatic report_and_stop();
    $display("comparisons %0d mismatches %0d", compares, err_total);
    if (err_total == 0 && compares > 0) begin
      $display("STATUS OK");
    end else begin
      $display("STATUS NOT OK");
    end
    $finish;
  endtask : report_and_stop

  always @(posedge clk) begin
    cycles++;
    if (cycles == 3000) begin
      err_total++;
      report_and_stop();
    end
  end

  task automatic check(input string name, input logic [7:0] exp,
                       input logic [7:0] got);
    compares++;
    if (got !== exp) begin
      err_total++;
      $display("wrong value %s expected %h seen %h", name, exp, got);
    end
  endtask : check

  task automatic check_flag(input string name, input logic exp,
                            input logic got);
    compares++;
    if (got !== exp) begin
      err_total++;
      $display("wrong value %s expected %b seen %b", name, exp, got);
    end
  endtask : check_flag

  task automatic rd(input logic [7:0] s, input logic [4:0] i,
                    input logic [7:0] exp, input logic bad);
    logic [7:0] d;
    logic       e;
    logic       v;
    rdr.read(s, i, d, e, v);
    check_flag("valid", 1'b1, v);
    check_flag("error", bad, e);
    check("data", exp, d);
  endtask : rd

  function automatic logic [7:0] base(input int i);
    case (i)
      1: base = 8'h15;
      4: base = 8'h71;
      5, 6: base = 8'h08;
      default: base = 8'h00;
    endcase
  endfunction : base

  initial begin
    err_total = 0;
    compares = 0;
    cycles = 0;
    flags = '0;
    ch_perr = '0;
    ch_val = '0;
    rst_b = 1'b0;
    repeat (16) @(posedge clk);
    #1 rst_b = 1'b1;
    for (int i = 0; i < 16; i++) begin
      rd(`REC_SET_FULL, i[4:0], base(i), 1'b0);
    end
    $display("test reset record done");
    for (int i = 0; i < 4; i++) begin
      rd(`REC_SET_SHORT, i[4:0], base(i), 1'b0);
    end
    rd(`REC_SET_SHORT, 5'h04, 8'h00, 1'b1);
    rd(8'h02, 5'h00, 8'h00, 1'b1);
    rd(`REC_SET_FULL, 5'h10, 8'h00, 1'b1);
    $display("test record sets done");
    for (int k = 0; k < 6; k++) begin
      flags = 6'h01 << k;
      repeat (4) @(posedge clk);
      rd(`REC_SET_FULL, (k == 5) ? 5'h03 : 5'h00, gexp[k], 1'b0);
      rd(`REC_SET_FULL, (k == 5) ? 5'h00 : 5'h03, 8'h00, 1'b0);
      flags = '0;
    end
    flags = 6'h06;
    repeat (4) @(posedge clk);
    rd(`REC_SET_FULL, 5'h00, 8'h06, 1'b0);
    flags = '0;
    $display("test general flags done");
    for (int n = 0; n < 8; n++) begin
      det = '0;
      case (n % 3)
        0: begin
          ch_val[16*n +: 16] = 16'h7F00;
          det.over = 1'b1;
        end
        1: begin
          ch_val[16*n +: 16] = 16'h8000;
          det.under = 1'b1;
        end
        default: begin
          ch_perr[n] = 1'b1;
          det.param_err = 1'b1;
        end
      endcase
      // Neighbour sits exactly on a limit and must stay clean
      ch_val[16*((n+1)%8) +: 16] = (n % 2) ? 16'h8100 : 16'h7EFF;
      repeat (4) @(posedge clk);
      rd(`REC_SET_FULL, 5'(8 + n), det, 1'b0);
      rd(`REC_SET_FULL, 5'(8 + (n + 1) % 8), 8'h00, 1'b0);
      rd(`REC_SET_FULL, 5'h07, 8'h01 << n, 1'b0);
      rd(`REC_SET_FULL, 5'h00, 8'h08, 1'b0);
      check("led", 8'h01 << n, led);
      ch_val = '0;
      ch_perr = '0;
      repeat (4) @(posedge clk);
      rd(`REC_SET_FULL, 5'h00, 8'h00, 1'b0);
    end
    $display("test channel errors done");
    report_and_stop();
  end
endmodule : analog_input_diagnostic_record_tb

`default_nettype wire

// *** diag_reader.sv ***
`timescale 1ns/1ps
`default_nettype none

module diag_reader (
  input  wire logic       clk_i,
  output var  logic       rd_req_o,
  output var  logic [7:0] set_o,
  output var  logic [4:0] index_o,
  input  wire logic       valid_i,
  input  wire logic [7:0] data_i,
  input  wire logic       error_i
);
  initial begin
    rd_req_o = 1'b0;
    set_o = 8'hA5;
    index_o = 5'h1A;
  end

  // One request per call, held until the edge that takes it
  task automatic read(input logic [7:0] s, input logic [4:0] i,
                      output logic [7:0] d, output logic e, output logic v);
    @(posedge clk_i);
    #1;
    rd_req_o = 1'b1;
    set_o = s;
    index_o = i;
    @(posedge clk_i);
    #1;
    v = valid_i;
    d = data_i;
    e = error_i;
    rd_req_o = 1'b0;
    // Released lines flip so a stale select never looks valid
    set_o = ~s;
    index_o = ~i;
  endtask : read
endmodule : diag_reader

`default_nettype wire

// *** pin_sync.sv ***
`timescale 1ns/1ps
`default_nettype none

module pin_sync #(
  parameter int W = 1
) (
  input  wire logic         clk_i,
  input  wire logic         rst_b_i,
  input  wire logic [W-1:0] d_i,
  output var  logic [W-1:0] q_o
);

  logic [W-1:0] stage1;

  always_ff @(posedge clk_i or negedge rst_b_i) begin
    if (!rst_b_i) begin
      stage1 <= '0;
      q_o    <= '0;
    end else begin
      stage1 <= d_i;
      q_o    <= stage1;
    end
  end

endmodule : pin_sync

`default_nettype wire

// *** range_monitor.sv ***
`timescale 1ns/1ps
`default_nettype none

module range_monitor #(
  parameter int                     VALUE_W     = 16,
  parameter logic signed [VALUE_W-1:0] OVER_LIMIT  = 16'sh7EFF,
  parameter logic signed [VALUE_W-1:0] UNDER_LIMIT = 16'sh8100
) (
  input  wire logic                      clk_i,
  input  wire logic                      rst_b_i,
  input  wire logic signed [VALUE_W-1:0] value_i,
  output var  logic                      under_o,
  output var  logic                      over_o
);

  // Values beyond the overrange band count as out of range
  wire logic next_under = value_i < UNDER_LIMIT;
  wire logic next_over  = value_i > OVER_LIMIT;

  always_ff @(posedge clk_i or negedge rst_b_i) begin
    if (!rst_b_i) begin
      under_o <= 1'b0;
      over_o  <= 1'b0;
    end else begin
      under_o <= next_under;
      over_o  <= next_over;
    end
  end

endmodule : range_monitor

`default_nettype wire
